//--- hw/exec_pkg.sv
// Purpose : shared constants, types and states of the trap/subroutine/operate executor
// Assumes : 16-bit words, byte addresses on the system bus, 40 MHz core_clk
// Notes   : octal opcodes and vectors are written here in hexadecimal

package exec_pkg;

	// -------------------------------------------------------------------------
	// timing
	// -------------------------------------------------------------------------
	localparam int CLK_FREQ_HZ         = 40_000_000;
	localparam int INIT_TIME_MS        = 20;
	localparam int INIT_CYCLES_DEFAULT = INIT_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int INIT_CNT_W          = 20;

	// -------------------------------------------------------------------------
	// opcodes and vectors
	// -------------------------------------------------------------------------
	localparam logic [15:0] OP_HALT        = 16'h0000;
	localparam logic [15:0] OP_WAIT        = 16'h0001;
	localparam logic [15:0] OP_DEBUG_TRAP  = 16'h0003;
	localparam logic [15:0] OP_IO_TRAP     = 16'h0004;
	localparam logic [15:0] OP_BUS_RESET   = 16'h0005;
	localparam logic [7:0]  OP_EMU_HI      = 8'h88;
	localparam logic [7:0]  OP_SWTRAP_HI   = 8'h89;
	localparam logic [10:0] OP_CCODE_HI    = 11'h005;
	localparam logic [12:0] OP_RETURN_HI   = 13'h0010;
	localparam logic [6:0]  OP_CALL_HI     = 7'h04;
	localparam logic [15:0] VEC_BUS_ERR    = 16'h0004;
	localparam logic [15:0] VEC_RESERVED   = 16'h0008;
	localparam logic [15:0] VEC_DEBUG_TRAP = 16'h000C;
	localparam logic [15:0] VEC_IO_TRAP    = 16'h0010;
	localparam logic [15:0] VEC_EMU_TRAP   = 16'h0018;
	localparam logic [15:0] VEC_SW_TRAP    = 16'h001C;
	localparam logic [15:0] WORD_STEP      = 16'h0002;
	localparam logic [7:0]  PSW_RESET      = 8'h00;

	// -------------------------------------------------------------------------
	// register map (byte offsets)
	// -------------------------------------------------------------------------
	localparam logic [4:0] REG_CTRL    = 5'h00;
	localparam logic [4:0] REG_STATUS  = 5'h04;
	localparam logic [4:0] REG_INT_ST  = 5'h08;
	localparam logic [4:0] REG_INT_MSK = 5'h0C;
	localparam logic [4:0] REG_PC      = 5'h10;
	localparam logic [4:0] REG_PSW     = 5'h14;
	localparam logic [4:0] REG_CONSOLE = 5'h18;
	localparam int CTRL_CONTINUE = 0;
	localparam int EV_HALT       = 0;
	localparam int EV_BUS_ERR    = 1;
	localparam int EV_TRAP       = 2;
	localparam int EV_INIT_DONE  = 3;
	localparam int EV_W          = 4;

	// -------------------------------------------------------------------------
	// types
	// -------------------------------------------------------------------------
	typedef enum logic [10:0] {
		st_halt    = 11'h001,
		st_fetch   = 11'h002,
		st_decode  = 11'h004,
		st_ind     = 11'h008,
		st_push_a  = 11'h010,
		st_push_b  = 11'h020,
		st_vec_pc  = 11'h040,
		st_vec_sw  = 11'h080,
		st_pop     = 11'h100,
		st_wait    = 11'h200,
		st_init    = 11'h400
	} cpu_state_type;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        pause;
		logic        byte_en;
		logic [15:0] addr;
		logic [15:0] wdata;
	} sys_req_type;

	typedef struct packed {
		logic        ack;
		logic        nxm;
		logic [15:0] rdata;
	} sys_rsp_type;

endpackage : exec_pkg

//--- hw/trap_subroutine_operate_exec.sv
// Purpose : executes trap, subroutine, halt, wait, bus reset and condition operators
// Assumes : system bus partner answers each request with a one-cycle ack or nxm
// Notes   : control and inspection over Avalon-MM with one wait state
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.

`timescale 1ns/1ps

module trap_subroutine_operate_exec
	import exec_pkg::*;
#(
	parameter int INIT_CYCLES = INIT_CYCLES_DEFAULT
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq,
	output sys_req_type      sys_req,
	input  wire sys_rsp_type sys_rsp,
	output logic             bus_init,
	input  wire logic        ext_irq,
	input  wire logic [7:0]  ext_vector
);

	// -------------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------------
	cpu_state_type state_q, state_d;
	sys_req_type   req_q, req_d;
	logic [15:0]   gpr_q [8];
	logic [15:0]   gpr_d [8];
	logic [7:0]    psw_q, psw_d;
	logic [15:0]   instruction_reg_q, instruction_reg_d;
	logic [15:0]   operand_latch_q, operand_latch_d;
	logic [15:0]   target_q, target_d;
	logic [15:0]   vec_q, vec_d;
	logic          call_q, call_d;
	logic          dbl_q, dbl_d;
	logic [15:0]   console_q, console_d;
	logic [INIT_CNT_W-1:0] cnt_q, cnt_d;
	logic          init_q, init_d;
	logic [EV_W-1:0] ev;

	logic          wait_q, wait_d;
	logic [31:0]   rdata_q, rdata_d;
	logic [EV_W-1:0] stat_q, stat_d;
	logic [EV_W-1:0] mask_q, mask_d;
	logic          irq_q, irq_d;

	logic          bus_done, bus_idle;
	logic          acc_wr, continue_key, wr_pc, wr_psw;
	logic [31:0]   wmask;
	logic [2:0]    link_sel, dst_sel;
	logic [2:0]    dst_mode;
	logic [3:0]    cc_sel;
	logic [15:0]   sp_dec;

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign irq             = irq_q;
	assign sys_req         = req_q;
	assign bus_init        = init_q;

	assign bus_idle = !(req_q.rd || req_q.wr);
	assign bus_done = !bus_idle && (sys_rsp.ack || sys_rsp.nxm);
	assign link_sel = instruction_reg_q[8:6];
	assign dst_sel  = instruction_reg_q[2:0];
	assign dst_mode = instruction_reg_q[5:3];
	assign cc_sel   = instruction_reg_q[3:0];
	assign sp_dec   = gpr_q[6] - WORD_STEP;

	// -------------------------------------------------------------------------
	// register access decode
	// -------------------------------------------------------------------------
	// a write takes effect only at the edge where waitrequest is seen low
	assign acc_wr       = avs_write && !wait_q;
	assign continue_key = acc_wr && avs_address == REG_CTRL && avs_byteenable[0]
		&& avs_writedata[CTRL_CONTINUE];
	assign wr_pc        = acc_wr && avs_address == REG_PC && state_q == st_halt;
	assign wr_psw       = acc_wr && avs_address == REG_PSW && state_q == st_halt;
	assign wmask        = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// -------------------------------------------------------------------------
	// execution sequencer
	// -------------------------------------------------------------------------
	always_comb begin
		state_d           = state_q;
		req_d             = req_q;
		gpr_d             = gpr_q;
		psw_d             = psw_q;
		instruction_reg_d = instruction_reg_q;
		operand_latch_d   = operand_latch_q;
		target_d          = target_q;
		vec_d             = vec_q;
		call_d            = call_q;
		dbl_d             = dbl_q;
		console_d         = console_q;
		cnt_d             = cnt_q;
		init_d            = init_q;
		ev                = '0;
		if (bus_done) begin
			req_d = '0;
		end
		unique case (state_q)
			st_halt: begin
				if (continue_key) begin
					dbl_d   = 1'b0;
					state_d = st_fetch;
				end
			end
			st_fetch: begin
				if (bus_idle) begin
					req_d = '{rd: 1'b1, wr: 1'b0, pause: 1'b0, byte_en: 1'b0,
						addr: gpr_q[7], wdata: 16'h0000};
				end else if (bus_done && sys_rsp.nxm) begin
					vec_d   = VEC_BUS_ERR;
					call_d  = 1'b0;
					ev[EV_BUS_ERR] = 1'b1;
					state_d = st_push_a;
				end else if (bus_done) begin
					instruction_reg_d = sys_rsp.rdata;
					operand_latch_d   = sys_rsp.rdata;
					gpr_d[7]          = gpr_q[7] + WORD_STEP;
					state_d           = st_decode;
				end
			end
			st_decode: begin
				call_d = 1'b0;
				if (instruction_reg_q == OP_HALT) begin
					console_d    = gpr_q[7];
					ev[EV_HALT]  = 1'b1;
					state_d      = st_halt;
				end else if (instruction_reg_q == OP_WAIT) begin
					state_d = st_wait;
				end else if (instruction_reg_q == OP_BUS_RESET) begin
					init_d  = 1'b1;
					cnt_d   = INIT_CNT_W'(INIT_CYCLES - 1);
					state_d = st_init;
				end else if (instruction_reg_q == OP_DEBUG_TRAP) begin
					vec_d   = VEC_DEBUG_TRAP;
					ev[EV_TRAP] = 1'b1;
					state_d = st_push_a;
				end else if (instruction_reg_q == OP_IO_TRAP) begin
					vec_d   = VEC_IO_TRAP;
					ev[EV_TRAP] = 1'b1;
					state_d = st_push_a;
				end else if (instruction_reg_q[15:8] == OP_EMU_HI) begin
					vec_d   = VEC_EMU_TRAP;
					ev[EV_TRAP] = 1'b1;
					state_d = st_push_a;
				end else if (instruction_reg_q[15:8] == OP_SWTRAP_HI) begin
					vec_d   = VEC_SW_TRAP;
					ev[EV_TRAP] = 1'b1;
					state_d = st_push_a;
				end else if (instruction_reg_q[15:5] == OP_CCODE_HI) begin
					// 240 and 260 select no flag and so fall out as no-operations
					psw_d[3:0] = instruction_reg_q[4] ? (psw_q[3:0] | cc_sel)
						: (psw_q[3:0] & ~cc_sel);
					state_d    = st_fetch;
				end else if (instruction_reg_q[15:3] == OP_RETURN_HI) begin
					gpr_d[7] = gpr_q[dst_sel];
					state_d  = st_pop;
				end else if (instruction_reg_q[15:9] == OP_CALL_HI
					&& (dst_mode == 3'd1 || dst_mode == 3'd2)) begin
					target_d = gpr_q[dst_sel];
					if (dst_mode == 3'd2) begin
						gpr_d[dst_sel] = gpr_q[dst_sel] + WORD_STEP;
					end
					call_d  = 1'b1;
					state_d = st_push_b;
				end else if (instruction_reg_q[15:9] == OP_CALL_HI && dst_mode == 3'd3) begin
					state_d = st_ind;
				end else begin
					// other modes and opcodes belong to other blocks; trap them here
					vec_d   = VEC_RESERVED;
					ev[EV_TRAP] = 1'b1;
					state_d = st_push_a;
				end
			end
			st_ind: begin
				if (bus_idle) begin
					req_d = '{rd: 1'b1, wr: 1'b0, pause: 1'b1,
						byte_en: instruction_reg_q[15],
						addr: gpr_q[dst_sel], wdata: 16'h0000};
				end else if (bus_done && sys_rsp.nxm) begin
					vec_d   = VEC_BUS_ERR;
					ev[EV_BUS_ERR] = 1'b1;
					state_d = st_push_a;
				end else if (bus_done) begin
					operand_latch_d = sys_rsp.rdata;
					target_d        = sys_rsp.rdata;
					gpr_d[dst_sel]  = gpr_q[dst_sel] + WORD_STEP;
					call_d          = 1'b1;
					state_d         = st_push_b;
				end
			end
			st_push_a, st_push_b: begin
				if (bus_idle) begin
					gpr_d[6] = sp_dec;
					req_d    = '{rd: 1'b0, wr: 1'b1, pause: 1'b0, byte_en: 1'b0,
						addr: sp_dec, wdata: 16'h0000};
					if (state_q == st_push_a) begin
						req_d.wdata = {8'h00, psw_q};
					end else if (call_q) begin
						req_d.wdata = gpr_q[link_sel];
					end else begin
						req_d.wdata = gpr_q[7];
					end
				end else if (bus_done && sys_rsp.nxm) begin
					// a fault while saving state cannot be serviced: stop instead
					dbl_d     = 1'b1;
					console_d = gpr_q[7];
					ev[EV_HALT] = 1'b1;
					ev[EV_BUS_ERR] = 1'b1;
					state_d   = st_halt;
				end else if (bus_done && state_q == st_push_a) begin
					state_d = st_push_b;
				end else if (bus_done && call_q) begin
					gpr_d[link_sel] = gpr_q[7];
					gpr_d[7]        = target_q;
					state_d         = st_fetch;
				end else if (bus_done) begin
					state_d = st_vec_pc;
				end
			end
			st_vec_pc, st_vec_sw: begin
				if (bus_idle) begin
					req_d = '{rd: 1'b1, wr: 1'b0, pause: 1'b0, byte_en: 1'b0,
						addr: (state_q == st_vec_pc) ? vec_q : vec_q + WORD_STEP,
						wdata: 16'h0000};
				end else if (bus_done && sys_rsp.nxm) begin
					dbl_d     = 1'b1;
					console_d = gpr_q[7];
					ev[EV_HALT] = 1'b1;
					ev[EV_BUS_ERR] = 1'b1;
					state_d   = st_halt;
				end else if (bus_done && state_q == st_vec_pc) begin
					gpr_d[7] = sys_rsp.rdata;
					state_d  = st_vec_sw;
				end else if (bus_done) begin
					psw_d   = sys_rsp.rdata[7:0];
					state_d = st_fetch;
				end
			end
			st_pop: begin
				if (bus_idle) begin
					req_d = '{rd: 1'b1, wr: 1'b0, pause: 1'b0, byte_en: 1'b0,
						addr: gpr_q[6], wdata: 16'h0000};
				end else if (bus_done && sys_rsp.nxm) begin
					vec_d   = VEC_BUS_ERR;
					ev[EV_BUS_ERR] = 1'b1;
					state_d = st_push_a;
				end else if (bus_done) begin
					gpr_d[6]       = gpr_q[6] + WORD_STEP;
					gpr_d[dst_sel] = sys_rsp.rdata;
					state_d        = st_fetch;
				end
			end
			st_wait: begin
				if (ext_irq) begin
					vec_d   = {8'h00, ext_vector};
					state_d = st_push_a;
				end
			end
			st_init: begin
				if (cnt_q == '0) begin
					init_d  = 1'b0;
					ev[EV_INIT_DONE] = 1'b1;
					state_d = st_fetch;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
		endcase
		if (state_d == st_halt) begin
			req_d = '0;
		end
		if (wr_pc) begin
			gpr_d[7] = (gpr_q[7] & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
		end
		if (wr_psw) begin
			psw_d = (psw_q & ~wmask[7:0]) | (avs_writedata[7:0] & wmask[7:0]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_q           <= st_halt;
			req_q             <= '0;
			gpr_q             <= '{default: 16'h0000};
			psw_q             <= PSW_RESET;
			instruction_reg_q <= 16'h0000;
			operand_latch_q   <= 16'h0000;
			target_q          <= 16'h0000;
			vec_q             <= 16'h0000;
			call_q            <= 1'b0;
			dbl_q             <= 1'b0;
			console_q         <= 16'h0000;
			cnt_q             <= '0;
			init_q            <= 1'b0;
		end else begin
			state_q           <= state_d;
			req_q             <= req_d;
			gpr_q             <= gpr_d;
			psw_q             <= psw_d;
			instruction_reg_q <= instruction_reg_d;
			operand_latch_q   <= operand_latch_d;
			target_q          <= target_d;
			vec_q             <= vec_d;
			call_q            <= call_d;
			dbl_q             <= dbl_d;
			console_q         <= console_d;
			cnt_q             <= cnt_d;
			init_q            <= init_d;
		end
	end

	// -------------------------------------------------------------------------
	// Avalon slave, event status and interrupt
	// -------------------------------------------------------------------------
	always_comb begin
		wait_d  = !((avs_read || avs_write) && wait_q);
		rdata_d = rdata_q;
		mask_d  = mask_q;
		stat_d  = stat_q;
		if (acc_wr && avs_address == REG_INT_ST) begin
			stat_d = stat_q & ~avs_writedata[EV_W-1:0];
		end
		stat_d = stat_d | ev;
		if (acc_wr && avs_address == REG_INT_MSK && avs_byteenable[0]) begin
			mask_d = avs_writedata[EV_W-1:0];
		end
		if (avs_read && wait_q) begin
			unique case (avs_address)
				REG_STATUS:  rdata_d = {28'h0000000, dbl_q, init_q,
					state_q == st_wait, state_q == st_halt};
				REG_INT_ST:  rdata_d = {28'h0000000, stat_q};
				REG_INT_MSK: rdata_d = {28'h0000000, mask_q};
				REG_PC:      rdata_d = {16'h0000, gpr_q[7]};
				REG_PSW:     rdata_d = {24'h000000, psw_q};
				REG_CONSOLE: rdata_d = {16'h0000, console_q};
				default:     rdata_d = 32'h00000000;
			endcase
		end
		irq_d = |(stat_q & mask_q);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h00000000;
			stat_q  <= '0;
			mask_q  <= '0;
			irq_q   <= 1'b0;
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
			stat_q  <= stat_d;
			mask_q  <= mask_d;
			irq_q   <= irq_d;
		end
	end

	// -------------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	a_fetch_pc_hold: assert property (
		state_q == st_fetch && !bus_idle && !bus_done |=> gpr_q[7] == $past(gpr_q[7]))
		else $error("pc moved before fetch completed");
	a_fetch_nxm_pc: assert property (
		state_q == st_fetch && bus_done && sys_rsp.nxm |=> gpr_q[7] == $past(gpr_q[7]))
		else $error("pc advanced on fetch bus error");
	a_emu_vector: assert property (
		state_q == st_decode && instruction_reg_q[15:8] == 8'h88
		|=> vec_q == 16'h0018 ##1 state_q == st_push_a)
		else $error("emulator trap vector wrong");
	a_swtrap_vector: assert property (
		state_q == st_decode && instruction_reg_q[15:8] == 8'h89 |=> vec_q == 16'h001C)
		else $error("software trap vector wrong");
	a_io_vector: assert property (
		state_q == st_decode && instruction_reg_q == 16'h0004 |=> vec_q == 16'h0010)
		else $error("io trap vector wrong");
	a_halt_quiet: assert property (
		state_q == st_halt |-> !sys_req.rd && !sys_req.wr && !bus_init)
		else $error("bus activity while halted");
	a_wait_quiet: assert property (
		state_q == st_wait |-> !sys_req.rd && !sys_req.wr)
		else $error("bus request during wait");
	a_cc_set: assert property (
		state_q == st_decode && instruction_reg_q[15:5] == 11'h005
		|=> psw_q[3:0] == ($past(instruction_reg_q[4]) ?
			($past(psw_q[3:0]) | $past(instruction_reg_q[3:0])) :
			($past(psw_q[3:0]) & ~$past(instruction_reg_q[3:0]))))
		else $error("condition operator result wrong");
	a_push_predec: assert property (
		$rose(sys_req.wr) |-> sys_req.addr == gpr_q[6] && gpr_q[6] == $past(gpr_q[6]) - 16'h0002)
		else $error("push did not predecrement stack pointer");
	a_vec_flags: assert property (
		state_q == st_vec_sw && bus_done && !sys_rsp.nxm
		|=> psw_q[3:0] == $past(sys_rsp.rdata[3:0]))
		else $error("flags not loaded from vector");
	a_init_hold: assert property (
		$rose(bus_init) |-> state_q == st_init ##1 (bus_init || state_q == st_fetch))
		else $error("bus init ended early");

	c_halt_resume: cover property (state_q == st_halt ##1 state_q == st_fetch);
	c_trap_done: cover property (state_q == st_vec_sw ##1 state_q == st_fetch);
	c_call_done: cover property (call_q && state_q == st_push_b ##1 state_q == st_fetch);
	c_wait_exit: cover property (state_q == st_wait ##1 state_q == st_push_a);

endmodule : trap_subroutine_operate_exec

//--- sim/sysbus_mem.sv
// Purpose : word memory standing on the system bus beside the executor
// Assumes : byte addresses 8000-BFFF hold nothing and answer nxm
// Notes   : answers alternate between prompt and slow
`timescale 1ns/1ps

module sysbus_mem
	import exec_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire sys_req_type sys_req,
	output sys_rsp_type      sys_rsp
);
	// -------------------------------------------------------------------------
	// storage and answer
	// -------------------------------------------------------------------------
	logic [15:0] mem [0:32767];
	logic [1:0]  wait_q;
	logic        slow_q;

	// released data lines flip every cycle so stale data never passes as valid
	always @(posedge core_clk) begin
		sys_rsp.ack <= 1'b0;
		sys_rsp.nxm <= 1'b0;
		sys_rsp.rdata <= ~sys_rsp.rdata;
		if (srst) begin
			wait_q <= 2'h0;
			slow_q <= 1'b0;
			sys_rsp.rdata <= 16'h0;
		end else if ((sys_req.rd || sys_req.wr) && !sys_rsp.ack && !sys_rsp.nxm) begin
			if (wait_q != (slow_q ? 2'h3 : 2'h0)) begin
				wait_q <= wait_q + 2'h1;
			end else begin
				wait_q <= 2'h0;
				slow_q <= ~slow_q;
				if (sys_req.addr[15:14] == 2'b10) begin
					sys_rsp.nxm <= 1'b1;
				end else begin
					sys_rsp.ack <= 1'b1;
					if (sys_req.rd) begin
						sys_rsp.rdata <= mem[sys_req.addr[15:1]];
					end else begin
						mem[sys_req.addr[15:1]] <= sys_req.wdata;
					end
				end
			end
		end
	end
endmodule : sysbus_mem

//--- sim/trap_subroutine_operate_exec_test.sv
// Purpose : self-checking bench for the trap, call and operate executor
// Assumes : INIT_CYCLES set to 8; programs preloaded into the bus memory
// Notes   : scenarios share one stack, so their order matters
`timescale 1ns/1ps

module trap_subroutine_operate_exec_test;
	import exec_pkg::*;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	sys_req_type sys_req;
	sys_rsp_type sys_rsp;
	logic        bus_init;
	logic        ext_irq = 1'b0;
	logic [7:0]  ext_vector = 8'h40;
	int          mismatches = 0;
	int          checked = 0;
	int          init_seen = 0;
	logic [31:0] rd_q;

	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (bus_init === 1'b1) init_seen++;

	trap_subroutine_operate_exec #(.INIT_CYCLES(8)) i_trap_subroutine_operate_exec (
		.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .sys_req(sys_req),
		.sys_rsp(sys_rsp), .bus_init(bus_init), .ext_irq(ext_irq), .ext_vector(ext_vector));
	sysbus_mem i_sysbus_mem (.core_clk(core_clk), .srst(srst), .sys_req(sys_req),
		.sys_rsp(sys_rsp));

	// -------------------------------------------------------------------------
	// shared tasks
	// -------------------------------------------------------------------------
	task stop_test;
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// waits one edge first so back-to-back calls never drive twice in a step
	task av(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd_q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			mismatches++;
			stop_test();
		end
	endtask : av

	task rdchk(input logic [4:0] a, input logic [31:0] exp);
		av(1'b0, a, 32'h0);
		chk(rd_q, exp);
	endtask : rdchk

	task mw(input logic [15:0] a, input logic [15:0] d);
		i_sysbus_mem.mem[a[15:1]] = d;
	endtask : mw

	task mchk(input logic [15:0] a, input logic [15:0] exp);
		chk({16'h0, i_sysbus_mem.mem[a[15:1]]}, {16'h0, exp});
	endtask : mchk

	task start(input logic [15:0] pc, input logic [7:0] psw);
		av(1'b1, REG_PC, {16'h0, pc});
		av(1'b1, REG_PSW, {24'h0, psw});
		av(1'b1, REG_INT_ST, 32'hF);
		av(1'b1, REG_CTRL, 32'h1);
	endtask : start

	// the sticky halt event avoids racing the status bit right after continue
	task poll(input logic [4:0] a, input int bitn);
		int n;
		n = 0;
		rd_q = 32'h0;
		while (rd_q[bitn] !== 1'b1 && n < 300) begin
			av(1'b0, a, 32'h0);
			n++;
		end
		if (rd_q[bitn] !== 1'b1) begin
			mismatches++;
			stop_test();
		end
	endtask : poll

	task run(input logic [15:0] pc, input logic [7:0] psw);
		start(pc, psw);
		poll(REG_INT_ST, EV_HALT);
	endtask : run

	// -------------------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------------------
	task t_reset;
		rdchk(REG_STATUS, 32'h1);
		rdchk(REG_PC, 32'h0);
		rdchk(5'h1C, 32'h0);
		chk(irq, 32'h0);
	endtask : t_reset

	task t_traps;
		mw(16'h0100, 16'h0003); mw(16'h000C, 16'h0200); mw(16'h000E, 16'h000F);
		mw(16'h0200, 16'h0004); mw(16'h0010, 16'h0300); mw(16'h0012, 16'h0005);
		mw(16'h0300, 16'h88FF); mw(16'h0018, 16'h0400); mw(16'h001A, 16'h000A);
		mw(16'h0400, 16'h8900); mw(16'h001C, 16'h0500); mw(16'h001E, 16'h0003);
		mw(16'h0500, 16'h0000);
		run(16'h0100, 8'h00);
		rdchk(REG_PC, 32'h502);
		rdchk(REG_CONSOLE, 32'h502);
		rdchk(REG_PSW, 32'h3);
		mchk(16'hFFFE, 16'h0000);
		mchk(16'hFFFC, 16'h0102);
		mchk(16'hFFFA, 16'h000F);
		mchk(16'hFFF8, 16'h0202);
		mchk(16'hFFF6, 16'h0005);
		mchk(16'hFFF4, 16'h0302);
		mchk(16'hFFF2, 16'h000A);
		mchk(16'hFFF0, 16'h0402);
		av(1'b1, REG_INT_MSK, 32'h4);
		repeat (3) @(posedge core_clk);
		#1 chk(irq, 32'h1);
		av(1'b1, REG_INT_ST, 32'h4);
		repeat (3) @(posedge core_clk);
		#1 chk(irq, 32'h0);
		av(1'b1, REG_INT_MSK, 32'h0);
	endtask : t_traps

	task t_ccodes;
		logic [23:0] tab [11];
		tab = '{24'h000BFF, 24'hF00A1E, 24'hF00A2D, 24'hF00A4B, 24'hF00A87, 24'hF00AF0,
			24'hF00A96, 24'h500A05, 24'h500B05, 24'h000B11, 24'h000B44};
		for (int i = 0; i < 11; i++) begin
			mw(16'h0600, tab[i][19:4]);
			mw(16'h0602, 16'h0000);
			run(16'h0600, {4'h0, tab[i][23:20]});
			rdchk(REG_PSW, {28'h0, tab[i][3:0]});
		end
	endtask : t_ccodes

	task t_call;
		mw(16'h0700, 16'h0950); mw(16'h0702, 16'h0950); mw(16'h0000, 16'h0085);
		mw(16'h0002, 16'h0000); mw(16'hFFEE, 16'hAAAA);
		run(16'h0700, 8'h09);
		rdchk(REG_PC, 32'h4);
		rdchk(REG_PSW, 32'h9);
		mchk(16'hFFEE, 16'h0000);
		// deferred call through a pointer at R0, returned from with the link register
		mw(16'h0710, 16'h0918); mw(16'h0712, 16'h0000); mw(16'h0004, 16'h0C00);
		mw(16'h0C00, 16'h0084);
		run(16'h0710, 8'h00);
		rdchk(REG_PC, 32'h714);
		mchk(16'hFFEC, 16'h0000);
	endtask : t_call

	task t_nxm;
		mw(16'h0004, 16'h0800); mw(16'h0006, 16'h0001); mw(16'h0800, 16'h0000);
		run(16'h8000, 8'h00);
		chk(rd_q[EV_BUS_ERR], 32'h1);
		rdchk(REG_PC, 32'h802);
		mchk(16'hFFEC, 16'h0000);
		mchk(16'hFFEA, 16'h8000);
	endtask : t_nxm

	task t_init;
		mw(16'h0900, 16'h0005); mw(16'h0902, 16'h0000);
		init_seen = 0;
		run(16'h0900, 8'h06);
		chk(32'(init_seen), 32'h8);
		rdchk(REG_PSW, 32'h6);
		rdchk(REG_PC, 32'h904);
	endtask : t_init

	task t_wait;
		int busy;
		mw(16'h0A00, 16'h0001); mw(16'h0040, 16'h0B00); mw(16'h0042, 16'h0002);
		mw(16'h0B00, 16'h0000);
		start(16'h0A00, 8'h00);
		poll(REG_STATUS, 1);
		busy = 0;
		repeat (30) @(posedge core_clk) if (sys_req.rd !== 1'b0 || sys_req.wr !== 1'b0) busy++;
		chk(32'(busy), 32'h0);
		ext_irq <= 1'b1;
		poll(REG_INT_ST, EV_HALT);
		ext_irq <= 1'b0;
		rdchk(REG_PC, 32'hB02);
		mchk(16'hFFE8, 16'h0000);
		mchk(16'hFFE6, 16'h0A02);
	endtask : t_wait

	initial begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		t_traps();
		t_ccodes();
		t_call();
		t_nxm();
		t_init();
		t_wait();
		chk(32'(init_seen), 32'h8);
		stop_test();
	end
endmodule : trap_subroutine_operate_exec_test
